// >>> ips_consts.svh
`ifndef IPS_CONSTS_SVH
`define IPS_CONSTS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define IPS_A_CTRL 8'h00
`define IPS_A_CMD 8'h04
`define IPS_A_RST 8'h08
`define IPS_A_PSEL 8'h0c
`define IPS_A_PW0 8'h10
`define IPS_A_PW4 8'h20
`define IPS_A_STAT 8'h24
// ----------------------------------------
// Limits and encodings
// ----------------------------------------
`define IPS_MIN_W 16'h0060
`define IPS_MIN_W_BIN 16'h0030
`define IPS_MIN_H 16'h0002
`define IPS_RESP_OK 2'h0
`define IPS_RESP_DEC 2'h3
`define IPS_BIN_NONE 2'h0
`endif

// >>> ips_pkg.sv
package ips_pkg;
   typedef enum logic [1:0] {
      IPS_NORMAL = 2'b00,
      IPS_TRIG_SEQ = 2'b01,
      IPS_CMD_SEQ = 2'b10
   } ips_mode_type;
   typedef enum logic [1:0] {
      IPS_G045 = 2'b00,
      IPS_G060 = 2'b01,
      IPS_G100 = 2'b10
   } ips_gamma_type;
   // Bin bit 0 is horizontal, bit 1 vertical.
   typedef struct packed {
      logic [15:0] width;
      logic [15:0] height;
      logic [15:0] offx;
      logic [15:0] offy;
      logic [23:0] exposure;
      logic [9:0] gain;
      logic [9:0] rgain;
      logic [9:0] bgain;
      logic [7:0] black;
      logic [1:0] bin;
      logic curve_en;
      logic [7:0] rep;
      logic [7:0] nxt;
   } ips_preset_type;
   typedef struct packed {
      ips_preset_type p;
      logic [15:0] read_lines;
      logic [7:0] index;
      logic gamma_on;
      logic [1:0] gamma;
      logic lut_on;
   } ips_applied_type;
endpackage

// >>> ips_sequencer.sv
// Contract
// R1 - Gamma choices 0.45, 0.60 and 1.0 (off) when curve source is gamma.
// R2 - Monochrome bins horizontally, vertically or both; color has no binning.
// R3 - Vertical binning halves lines read out per frame.
// R4 - Binning is disabled while video processing bypass is on.
// R5 - ROI is width, height, X and Y offset; only it is scanned.
// R6 - Minimum width 96, 48 with mono binning; minimum height 2.
// R7 - Output mode is normal, trigger sequence or commanded sequence.
// R8 - Up to 128 presets, one applied per trigger.
// R9 - Preset holds ROI, exposure, gains, black, binning, curve, repeat, next.
// R10 - Sequencing needs an enable and a submode choice.
// R11 - Trigger sequence starts at preset 1 on entry.
// R12 - Preset repeats for its count, then successor is used.
// R13 - Successor 1 loops the pattern back to the start.
// R14 - Restart forces preset 1 for the next trigger.
// R15 - Commanded mode applies the commanded index on every trigger.
// R16 - Sequence curve source picks gamma or table; gamma applies to all.
// R17 - Table applies only to presets with curve enable set.
// R18 - Host writes commanded index 1 to 128.
// R19 - Commanded mode ignores repeat, successor and restart.
// R20 - Repeat counter clears whenever the active preset changes.
// R21 - Preset settings change only at a frame boundary.
`timescale 1ns/100ps
`include "ips_consts.svh"
module ips_sequencer import ips_pkg::*; (
   input wire logic ref_clk, // 250 MHz clock
   input wire logic resetn, // sync reset
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read valid
   input wire logic s_axi_rready, // read ready
   input wire logic trig_in, // trigger pin
   input wire logic mono_strap, // model pin, high = mono
   input wire logic frame_done, // end of frame pulse
   output logic frame_start, // preset applied pulse
   output logic frame_busy, // frame in progress
   output ips_applied_type applied // settings of this frame
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   function automatic logic [6:0] idx0(input logic [7:0] v);
      idx0 = (v == 8'h00) ? 7'h00 : 7'(v - 8'h01);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
      end
   endfunction

   function automatic logic [15:0] max16(input logic [15:0] a,
      input logic [15:0] b);
      max16 = (a < b) ? b : a;
   endfunction

   function automatic logic [31:0] p2w(input ips_preset_type p,
      input logic [2:0] k);
      case (k)
         3'h0: p2w = {p.height, p.width};
         3'h1: p2w = {p.offy, p.offx};
         3'h2: p2w = {8'h00, p.exposure};
         3'h3: p2w = {2'b00, p.bgain, p.rgain, p.gain};
         3'h4: p2w = {p.nxt, p.rep, 3'b000, p.curve_en, 2'b00, p.bin,
            p.black};
         default: p2w = 32'h0000_0000;
      endcase
   endfunction

   function automatic ips_preset_type w2p(input ips_preset_type p,
      input logic [2:0] k, input logic [31:0] w);
      w2p = p;
      case (k)
         3'h0: {w2p.height, w2p.width} = w;
         3'h1: {w2p.offy, w2p.offx} = w;
         3'h2: w2p.exposure = w[23:0];
         3'h3: {w2p.bgain, w2p.rgain, w2p.gain} = w[29:0];
         3'h4: begin
            {w2p.nxt, w2p.rep} = w[31:16];
            w2p.curve_en = w[12];
            {w2p.bin, w2p.black} = w[9:0];
         end
         default: w2p = p;
      endcase
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic trig_s1_q, trig_s2_q, trig_s3_q, mono_s1_q, mono_q;
   always_ff @(posedge ref_clk) begin
      trig_s1_q <= trig_in;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
      mono_s1_q <= mono_strap;
      mono_q <= mono_s1_q;
   end
   wire trig_edge = trig_s2_q && !trig_s3_q;

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
   logic [7:0] aw_q;
   logic [31:0] wd_q, rdata_q;
   logic [3:0] ws_q;
   logic [1:0] bresp_q, rresp_q;
   logic [1:0] mode_q, gam_q;
   logic seq_en_q, ocs_q, scs_q, byp_q;
   logic [7:0] cmd_q;
   logic [6:0] psel_q;
   ips_preset_type mem_q [0:127]; // R8

   wire [7:0] wa = {aw_q[7:2], 2'b00};
   wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
   wire do_wr = aw_have_q && w_have_q && !bvalid_q;
   wire do_rd = s_axi_arvalid && !rvalid_q;
   wire wr_ctrl = do_wr && wa == `IPS_A_CTRL;
   wire wr_cmd = do_wr && wa == `IPS_A_CMD;
   wire wr_rst = do_wr && wa == `IPS_A_RST;
   wire wr_psel = do_wr && wa == `IPS_A_PSEL;
   wire w_pre = wa >= `IPS_A_PW0 && wa <= `IPS_A_PW4;
   wire r_pre = ra >= `IPS_A_PW0 && ra <= `IPS_A_PW4;
   wire [7:0] wk8 = (wa - `IPS_A_PW0) >> 2;
   wire [7:0] rk8 = (ra - `IPS_A_PW0) >> 2;
   wire w_map = w_pre || wa <= `IPS_A_PSEL || wa == `IPS_A_STAT;
   wire r_map = r_pre || ra <= `IPS_A_PSEL || ra == `IPS_A_STAT;
   wire [31:0] ctrl_word = {24'h000000, byp_q, gam_q, scs_q, ocs_q,
      seq_en_q, mode_q};
   wire ips_preset_type pcur = mem_q[psel_q];
   wire [31:0] pw_old = p2w(pcur, wk8[2:0]);

   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready = !w_have_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `IPS_RESP_OK;
         aw_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_have_q) begin
            aw_have_q <= 1'b1;
            aw_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_have_q) begin
            w_have_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= w_map ? `IPS_RESP_OK : `IPS_RESP_DEC;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Settings and preset store
   // ----------------------------------------
   wire [31:0] ctrl_new = merge(ctrl_word, wd_q, ws_q);
   wire [31:0] cmd_new = merge({24'h000000, cmd_q}, wd_q, ws_q);
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         mode_q <= IPS_NORMAL;
         seq_en_q <= 1'b0;
         ocs_q <= 1'b0;
         scs_q <= 1'b0;
         gam_q <= IPS_G100;
         byp_q <= 1'b0;
         cmd_q <= 8'h01;
         psel_q <= 7'h00;
      end else begin
         if (wr_ctrl) begin
            {byp_q, gam_q, scs_q, ocs_q, seq_en_q, mode_q} <=
               ctrl_new[7:0]; // R7 R10 R16 R1
         end
         if (wr_cmd) begin
            cmd_q <= cmd_new[7:0]; // R15
         end
         if (wr_psel) begin
            psel_q <= wd_q[6:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (do_wr && w_pre) begin
         mem_q[psel_q] <= w2p(pcur, wk8[2:0],
            merge(pw_old, wd_q, ws_q)); // R9
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   logic [6:0] cur_q;
   logic [7:0] cnt_q;
   logic tseq_q, busy_q, start_q;
   ips_applied_type app_q;

   wire tseq = seq_en_q && mode_q == IPS_TRIG_SEQ; // R7 R10
   wire cseq = seq_en_q && mode_q == IPS_CMD_SEQ; // R7 R10
   wire accept = trig_edge && !busy_q; // R21
   wire [6:0] sel = tseq ? cur_q : (cseq ? idx0(cmd_q) : 7'h00); // R15
   wire ips_preset_type p = mem_q[sel];
   wire [8:0] rep_eff = (p.rep == 8'h00) ? 9'h001 : {1'b0, p.rep};
   wire last = {1'b0, cnt_q} + 9'h001 >= rep_eff; // R12
   wire [6:0] nxt0 = idx0(p.nxt); // R13
   wire restart = wr_rst && tseq; // R19

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cur_q <= 7'h00;
         cnt_q <= 8'h00;
         tseq_q <= 1'b0;
      end else begin
         tseq_q <= tseq;
         if (tseq && (!tseq_q || restart)) begin
            cur_q <= 7'h00; // R11 R14
            cnt_q <= 8'h00; // R20
         end else if (accept && tseq) begin
            if (last) begin
               cur_q <= nxt0; // R12 R13
               cnt_q <= 8'h00; // R20
            end else begin
               cnt_q <= cnt_q + 8'h01; // R12
            end
         end else if (wr_cmd) begin
            cnt_q <= 8'h00; // R20
         end
      end
   end

   // ----------------------------------------
   // Preset shaping
   // ----------------------------------------
   wire [1:0] bin = (mono_q && !byp_q) ? p.bin : `IPS_BIN_NONE; // R2 R4
   wire [15:0] minw = (bin != `IPS_BIN_NONE) ? `IPS_MIN_W_BIN :
      `IPS_MIN_W; // R6
   wire [15:0] w_eff = max16(p.width, minw); // R5 R6
   wire [15:0] h_eff = max16(p.height, `IPS_MIN_H); // R5 R6
   wire [15:0] lines = bin[1] ? (h_eff >> 1) : h_eff; // R3
   wire lut_src = (tseq || cseq) ? scs_q : ocs_q; // R16
   wire lut_on = lut_src && (!(tseq || cseq) || p.curve_en); // R17
   wire gam_on = !lut_src && gam_q != IPS_G100; // R1 R16

   ips_applied_type app_d;
   always_comb begin
      app_d = '0;
      app_d.p = p;
      app_d.p.width = w_eff;
      app_d.p.height = h_eff;
      app_d.p.bin = bin;
      app_d.p.rgain = mono_q ? 10'h000 : p.rgain;
      app_d.p.bgain = mono_q ? 10'h000 : p.bgain;
      app_d.read_lines = lines;
      app_d.index = {1'b0, sel} + 8'h01;
      app_d.gamma_on = gam_on;
      app_d.gamma = gam_q;
      app_d.lut_on = lut_on;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         busy_q <= 1'b0;
         start_q <= 1'b0;
         app_q <= '0;
      end else begin
         start_q <= accept;
         if (accept) begin
            busy_q <= 1'b1;
            app_q <= app_d; // R8 R21
         end else if (frame_done) begin
            busy_q <= 1'b0;
         end
      end
   end
   assign frame_start = start_q;
   assign frame_busy = busy_q;
   assign applied = app_q;

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   wire [31:0] stat = {14'h0000, mono_q, busy_q, cnt_q, 1'b0, cur_q};
   wire [31:0] rd_w =
      (ra == `IPS_A_CTRL) ? ctrl_word :
      (ra == `IPS_A_CMD) ? {24'h000000, cmd_q} :
      (ra == `IPS_A_PSEL) ? {25'h0000000, psel_q} :
      (ra == `IPS_A_STAT) ? stat :
      r_pre ? p2w(pcur, rk8[2:0]) : 32'h0000_0000;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `IPS_RESP_OK;
      end else if (do_rd) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_w;
         rresp_q <= r_map ? `IPS_RESP_OK : `IPS_RESP_DEC;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_restart_first: assert property (restart |=> cur_q == 7'h00 &&
      cnt_q == 8'h00) else $error("restart missed"); // R14
   a_entry_first: assert property ($rose(tseq) |=> cur_q == 7'h00)
      else $error("entry not at first"); // R11
   a_repeat_next: assert property (accept && tseq && tseq_q && last &&
      !restart |=> cur_q == $past(nxt0)) else $error("no advance"); // R12
   a_repeat_hold: assert property (accept && tseq && tseq_q && !last &&
      !restart |=> cur_q == $past(cur_q) && cnt_q == $past(cnt_q) + 8'h01)
      else $error("repeat count off"); // R12
   a_cmd_index: assert property (accept && cseq && cmd_q != 8'h00 |=>
      applied.index == $past(cmd_q)) else $error("bad index"); // R15
   a_bin_bypass: assert property (frame_start && $past(byp_q) |->
      applied.p.bin == `IPS_BIN_NONE) else $error("bin in bypass"); // R4
   a_color_nobin: assert property (frame_start && !$past(mono_q) |->
      applied.p.bin == `IPS_BIN_NONE) else $error("color binned"); // R2
   a_min_roi: assert property (frame_start |-> applied.p.height >=
      `IPS_MIN_H && (applied.p.width >= `IPS_MIN_W ||
      applied.p.bin != `IPS_BIN_NONE)) else $error("roi small"); // R6
   a_curve_excl: assert property (frame_start |->
      !(applied.gamma_on && applied.lut_on)) else $error("two curves"); // R16
   a_frame_hold: assert property (busy_q && !frame_done |=>
      $stable(applied)) else $error("mid frame change"); // R21
endmodule

// >>> ips_trig_src.sv
`timescale 1ns/100ps
module ips_trig_src #(
   parameter int DLY = 6 // cycles to frame end from frame start, or from the end of the stray pulse
) (
   input wire logic ref_clk, // clock
   input wire logic fire, // request one frame
   input wire logic stray, // also pulse the pin while the frame runs
   input wire logic frame_start, // frame accepted
   output logic trig_in, // trigger pin
   output logic frame_done, // end of frame pulse
   output logic done // frame finished
);
   // ----------------------------------------
   // Trigger and frame end source
   // ----------------------------------------
   // A stray pulse lands while busy; the block must not start a frame on it.
   initial begin
      trig_in = 1'b0;
      frame_done = 1'b0;
      done = 1'b0;
      forever begin
         @(posedge ref_clk);
         if (fire) begin
            trig_in <= 1'b1;
            repeat (3) @(posedge ref_clk);
            trig_in <= 1'b0;
            while (frame_start !== 1'b1) @(posedge ref_clk);
            if (stray) begin
               @(posedge ref_clk);
               trig_in <= 1'b1;
               repeat (3) @(posedge ref_clk);
               trig_in <= 1'b0;
            end
            repeat (DLY) @(posedge ref_clk);
            frame_done <= 1'b1;
            @(posedge ref_clk);
            frame_done <= 1'b0;
            done <= 1'b1;
            @(posedge ref_clk);
            done <= 1'b0;
         end
      end
   end
endmodule

// >>> ips_testbench.sv
`timescale 1ns/100ps
`include "ips_consts.svh"
module testbench import ips_pkg::*;;
   logic ref_clk, resetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic trig_in, mono_strap, frame_done, frame_start, frame_busy;
   logic fire, stray, done;
   ips_applied_type applied;
   int failures, checks_done, cyc;

   ips_sequencer dut_u (.ref_clk(ref_clk), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trig_in(trig_in),
      .mono_strap(mono_strap), .frame_done(frame_done),
      .frame_start(frame_start), .frame_busy(frame_busy), .applied(applied));
   ips_trig_src src_u (.ref_clk(ref_clk), .fire(fire), .stray(stray),
      .frame_start(frame_start), .trig_in(trig_in),
      .frame_done(frame_done), .done(done));

   // ----------------------------------------
   // Bus and trigger tasks
   // ----------------------------------------
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk("bresp", 32'(er), 32'(bresp));
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk("rdata", ed, rdata);
      chk("rresp", 32'(er), 32'(rresp));
   endtask

   function automatic logic [31:0] w4(input logic [7:0] n, r,
                                      input logic c, input logic [1:0] b);
      return {n, r, 3'h0, c, 2'h0, b, 8'h00};
   endfunction

   task automatic set_preset(input logic [6:0] i, input logic [15:0] w, h,
                             input logic [31:0] wd4);
      axi_wr(`IPS_A_PSEL, {25'h0, i}, `IPS_RESP_OK);
      axi_wr(`IPS_A_PW0, {h, w}, `IPS_RESP_OK);
      axi_wr(`IPS_A_PW0 + 8'h04, 32'h0004_0008, `IPS_RESP_OK);
      axi_wr(`IPS_A_PW0 + 8'h08, 32'h0000_1234, `IPS_RESP_OK);
      axi_wr(`IPS_A_PW0 + 8'h0c, 32'h0030_0801, `IPS_RESP_OK);
      axi_wr(`IPS_A_PW4, wd4, `IPS_RESP_OK);
   endtask

   task automatic shot(input logic s, input logic [7:0] ei);
      fire <= 1'b1;
      stray <= s;
      @(posedge ref_clk);
      fire <= 1'b0;
      while (frame_start !== 1'b1) @(posedge ref_clk);
      chk("busy", 32'h1, 32'(frame_busy));
      while (done !== 1'b1) @(posedge ref_clk);
      chk("busy", 32'h0, 32'(frame_busy));
      chk("index", 32'(ei), 32'(applied.index));
   endtask

   task automatic roi(input logic m, input logic [31:0] c,
                      input logic [15:0] w, h, input logic [1:0] b,
                      input logic [15:0] ew, eh, el, input logic [1:0] eb);
      mono_strap <= m;
      axi_wr(`IPS_A_CTRL, c, `IPS_RESP_OK);
      set_preset(7'h0, w, h, w4(8'h1, 8'h1, 1'b0, b));
      shot(1'b0, 8'h1);
      chk("width", 32'(ew), 32'(applied.p.width));
      chk("height", 32'(eh), 32'(applied.p.height));
      chk("lines", 32'(el), 32'(applied.read_lines));
      chk("bin", 32'(eb), 32'(applied.p.bin));
      chk("offx", 32'h8, 32'(applied.p.offx));
      chk("exposure", 32'h1234, 32'(applied.p.exposure));
      chk("rgain", m ? 32'h0 : 32'h2, 32'(applied.p.rgain));
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_seq;
      logic [7:0] seq [7] = '{8'h1, 8'h1, 8'h2, 8'h80, 8'h1, 8'h1, 8'h2};
      axi_rd(`IPS_A_CTRL, 32'h40, `IPS_RESP_OK);
      axi_rd(8'h40, 32'h0, `IPS_RESP_DEC);
      axi_wr(8'h44, 32'h5, `IPS_RESP_DEC);
      set_preset(7'h0, 16'hc8, 16'h64, w4(8'h2, 8'h2, 1'b0, 2'h0));
      set_preset(7'h1, 16'hc8, 16'h64, w4(8'h80, 8'h1, 1'b0, 2'h0));
      set_preset(7'h7f, 16'hc8, 16'h64, w4(8'h1, 8'h1, 1'b0, 2'h0));
      axi_rd(`IPS_A_PW4, w4(8'h1, 8'h1, 1'b0, 2'h0), `IPS_RESP_OK);
      axi_wr(`IPS_A_CTRL, 32'h45, `IPS_RESP_OK);
      axi_rd(`IPS_A_CTRL, 32'h45, `IPS_RESP_OK);
      foreach (seq[i]) shot(i == 3, seq[i]);
      axi_wr(`IPS_A_RST, 32'h1, `IPS_RESP_OK);
      shot(1'b0, 8'h1);
      axi_rd(`IPS_A_STAT, 32'h0000_0100, `IPS_RESP_OK);
      axi_wr(`IPS_A_RST, 32'h1, `IPS_RESP_OK);
      shot(1'b0, 8'h1);
      shot(1'b0, 8'h1);
      axi_wr(`IPS_A_CTRL, 32'h40, `IPS_RESP_OK);
      axi_wr(`IPS_A_CTRL, 32'h45, `IPS_RESP_OK);
      shot(1'b0, 8'h1);
      axi_wr(`IPS_A_CTRL, 32'h41, `IPS_RESP_OK);
      repeat (3) shot(1'b0, 8'h1);
      $display("trigger sequence test done");
   endtask

   task automatic t_cmd;
      axi_wr(`IPS_A_CTRL, 32'h46, `IPS_RESP_OK);
      axi_wr(`IPS_A_CMD, 32'h2, `IPS_RESP_OK);
      repeat (3) shot(1'b0, 8'h2);
      axi_wr(`IPS_A_CMD, 32'h80, `IPS_RESP_OK);
      shot(1'b0, 8'h80);
      axi_wr(`IPS_A_RST, 32'h1, `IPS_RESP_OK);
      shot(1'b0, 8'h80);
      axi_wr(`IPS_A_CMD, 32'h1, `IPS_RESP_OK);
      shot(1'b0, 8'h1);
      $display("commanded sequence test done");
   endtask

   task automatic t_curve;
      set_preset(7'h0, 16'hc8, 16'h64, w4(8'h2, 8'h1, 1'b1, 2'h0));
      set_preset(7'h1, 16'hc8, 16'h64, w4(8'h1, 8'h1, 1'b0, 2'h0));
      axi_wr(`IPS_A_CTRL, 32'h55, `IPS_RESP_OK);
      shot(1'b0, 8'h1);
      chk("lut_on", 32'h1, 32'(applied.lut_on));
      shot(1'b0, 8'h2);
      chk("lut_on", 32'h0, 32'(applied.lut_on));
      for (int g = 0; g < 3; g++) begin
         axi_wr(`IPS_A_CTRL, {25'h0, 2'(g), 5'h06}, `IPS_RESP_OK);
         shot(1'b0, 8'h1);
         chk("gamma", 32'(g), 32'(applied.gamma));
         chk("gamma_on", 32'(g != 2), 32'(applied.gamma_on));
         chk("lut_on", 32'h0, 32'(applied.lut_on));
      end
      axi_wr(`IPS_A_CTRL, 32'h08, `IPS_RESP_OK);
      shot(1'b0, 8'h1);
      chk("lut_on", 32'h1, 32'(applied.lut_on));
      chk("gamma_on", 32'h0, 32'(applied.gamma_on));
      $display("curve test done");
   endtask

   task automatic t_roi;
      roi(1'b0, 32'h40, 16'ha, 16'h1, 2'h3, `IPS_MIN_W, `IPS_MIN_H,
          `IPS_MIN_H, 2'h0);
      roi(1'b1, 32'h40, 16'ha, 16'h1, 2'h0, `IPS_MIN_W, `IPS_MIN_H,
          `IPS_MIN_H, 2'h0);
      roi(1'b1, 32'h40, 16'ha, 16'h1, 2'h1, `IPS_MIN_W_BIN, `IPS_MIN_H,
          `IPS_MIN_H, 2'h1);
      roi(1'b1, 32'h40, 16'h140, 16'h64, 2'h2, 16'h140, 16'h64,
          16'h32, 2'h2);
      roi(1'b1, 32'hc0, 16'ha, 16'h64, 2'h3, `IPS_MIN_W, 16'h64,
          16'h64, 2'h0);
      $display("region test done");
   endtask

   // ----------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         $display("ERROR timeout expected 0 seen %0d", cyc);
         end_sim();
      end
   end

   initial begin
      resetn = 1'b0;
      {awvalid, wvalid, arvalid, fire, stray, mono_strap} = '0;
      {bready, rready} = 2'b11;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      t_seq();
      t_cmd();
      t_curve();
      t_roi();
      end_sim();
   end
endmodule
